// ==== design/hcf_cap_regs.sv ====
// Capability flag register bank with wide addressing control over AXI4-Lite
//
// Overview of operation
// RULE1: From version 4.00 a control bit selects older or newer wide addressing mode.
// RULE2: Older mode needs v3_wide_addr_cap, newer mode needs v4_wide_addr_cap.
// RULE3: From 4.00 wide DMA addressing is active only when wide_dma_addr_en is set.
// RULE4: Simple DMA with wide addresses is refused in older mode, allowed in newer.
// RULE5: Advanced descriptors are 96 bits in older mode, 128 bits in newer mode.
// RULE6: Without v3_wide_addr_cap the 96-bit descriptor form is not supported.
// RULE7: On 3.00 the 96-bit descriptor is chosen by dma_mode_sel code 11b.
// RULE8: With v4_wide_addr_cap registers decode on the full 64-bit address. Here only bits 63:32 and 7:0 are decoded; bits 31:8 are ignored.
// RULE9: Narrow-decoding older parts must be placed below 4 GB by the system.
// RULE10: Bit 23 reports suspend/resume; software skips those commands when clear.
// RULE11: Bit 22 reports simple DMA; 4.10 parts with advanced DMA must set it.
// RULE12: Bit 21 set only if 25 to 50 MHz card clock is available.
// RULE13: Bit 20 is reserved; when set it marks legacy advanced DMA.
// RULE14: Bit 19 reports advanced DMA v2; 4.10 parts with gen-3 DMA must set it.
// RULE15: Bit 18 reports 8-bit bus; shared slot uses preset_bus_width instead.
// RULE16: Bits 17-16 give block size: 00 512, 10 2048, 11 reserved.
// RULE17: Software always uses 512-byte blocks for memory cards.
// RULE18: Flags are fixed at reset and read-only; writes have no effect.
// RULE19: Block size code 01 means 1024 bytes.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "hcf_consts.svh"
module hcf_cap_regs
  import hcf_pkg::*;
#(
  parameter logic [7:0] CTRL_VERSION  = `HCF_VER_410,
  parameter logic [3:0] ID_REVISION   = 4'hA,   // Arbitrary revision tag
  parameter logic [1:0] BLK_SIZE_CODE = `HCF_BLK_512
)
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Hardware strap pins sampled after reset
  input  wire logic         strapV3Wide,
  input  wire logic         strapV4Wide,
  input  wire logic         strapSuspend,
  input  wire logic         strapSimpleDma,
  input  wire logic         strapHighSpeed,
  input  wire logic         strapLegacyAdma,
  input  wire logic         strapAdma2,
  input  wire logic         strapAdma3,
  input  wire logic         strapBus8,
  // AXI4-Lite write address
  input  wire logic [63:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [63:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Decoded mode for the DMA engines
  output logic              wideDmaActive,
  output logic              simpleWideOk,
  output logic              desc128Sel,
  output logic              desc96Sel,
  output logic              bus8Usable
);
  import hcf_pkg::*;

  // Strap synchronisers, capture flags and the capture-done marker
  logic [8:0]  strapMeta_ff;
  logic [8:0]  strapSync_ff;
  logic [1:0]  capWait_ff;
  logic [31:0] capFlags_ff;
  logic [31:0] nxt_capFlags;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  // Write channel holding registers
  logic        awHave_ff;
  logic [63:0] awAddr_ff;
  logic        wHave_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  // Read channel
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  // Decode
  hcf_addr_mode_t addrMode;
  logic        advDmaErr;
  logic        dec64;
  logic        doWrite;
  logic        doRead;
  logic        wrHit;
  logic        rdHit;
  logic [31:0] rdValue;
  logic [31:0] statWord;
  logic [8:0]  strapIn;

  assign strapIn = {strapBus8, strapAdma3, strapAdma2, strapLegacyAdma, strapHighSpeed,
                    strapSimpleDma, strapSuspend, strapV4Wide, strapV3Wide};

  // Pins come from outside the clock domain; two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strapMeta_ff <= 9'h000;
      strapSync_ff <= 9'h000;
    end else begin
      strapMeta_ff <= strapIn;
      strapSync_ff <= strapMeta_ff;
    end
  end

  // Flags load on each of the first three edges, the last after the synchroniser has settled, then never change
  always_comb begin
    nxt_capFlags = 32'h0000_0000;
    nxt_capFlags[`HCF_BIT_V3WIDE]     = strapSync_ff[0];
    // V4 flag is only defined from 4.10 on
    nxt_capFlags[`HCF_BIT_V4WIDE]     = strapSync_ff[1] && (CTRL_VERSION >= `HCF_VER_410);
    nxt_capFlags[`HCF_BIT_SUSPEND]    = strapSync_ff[2]; // RULE10
    // A 4.10 part with advanced DMA always offers simple DMA
    nxt_capFlags[`HCF_BIT_SIMPLEDMA]  = strapSync_ff[3] || ((CTRL_VERSION >= `HCF_VER_410)
                                        && (strapSync_ff[6] || strapSync_ff[7])); // RULE11
    nxt_capFlags[`HCF_BIT_HIGHSPEED]  = strapSync_ff[4]; // RULE12
    nxt_capFlags[`HCF_BIT_LEGACYADMA] = strapSync_ff[5]; // RULE13
    // Third-generation DMA implies version 2 on 4.10 parts
    nxt_capFlags[`HCF_BIT_ADMA2]      = strapSync_ff[6] || ((CTRL_VERSION >= `HCF_VER_410)
                                        && strapSync_ff[7]); // RULE14
    nxt_capFlags[`HCF_BIT_BUS8]       = strapSync_ff[8]; // RULE15
    // Reserved code is never reported; fall back to 512 bytes
    nxt_capFlags[`HCF_BLK_LSB+1:`HCF_BLK_LSB] = (BLK_SIZE_CODE == `HCF_BLK_RSVD) ?
                                        `HCF_BLK_512 : BLK_SIZE_CODE; // RULE16 RULE19
  end

  // Capture window closes after three edges so later strap noise cannot alter a flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capWait_ff  <= 2'h0;
      capFlags_ff <= 32'h0000_0000;
    end else if (capWait_ff != 2'h3) begin
      capWait_ff  <= capWait_ff + 2'h1;
      capFlags_ff <= nxt_capFlags; // RULE18
    end
  end

  // Mode decoding is kept apart from the bus logic
  hcf_mode_decode u_mode (
    .v3WideAddrCap (capFlags_ff[`HCF_BIT_V3WIDE]),
    .v4WideAddrCap (capFlags_ff[`HCF_BIT_V4WIDE]),
    .ctrlVersion   (CTRL_VERSION),
    .v4ModeSelect  (ctrl_ff[`HCF_CTRL_V4SEL]),
    .wideDmaAddrEn (ctrl_ff[`HCF_CTRL_WIDEEN]),
    .dmaModeSel    (ctrl_ff[`HCF_CTRL_DMA_LSB+1:`HCF_CTRL_DMA_LSB]),
    .addrMode      (addrMode),
    .wideDmaActive (wideDmaActive),
    .simpleWideOk  (simpleWideOk),
    .desc128Sel    (desc128Sel),
    .desc96Sel     (desc96Sel),
    .advDmaErr     (advDmaErr)
  );

  // Shared slots ignore the 8-bit flag and use the preset width bit
  assign bus8Usable = (ctrl_ff[`HCF_CTRL_SLOT_LSB+1:`HCF_CTRL_SLOT_LSB] == `HCF_SLOT_SHARED)
                      ? ctrl_ff[`HCF_CTRL_PRESET8] : capFlags_ff[`HCF_BIT_BUS8]; // RULE15

  // With the V4 flag the upper address word must be zero to hit; otherwise ignored
  assign dec64 = capFlags_ff[`HCF_BIT_V4WIDE]; // RULE8
  assign wrHit = !dec64 || (awAddr_ff[63:32] == 32'h0000_0000); // RULE8
  assign rdHit = !dec64 || (s_axi_araddr[63:32] == 32'h0000_0000); // RULE8

  // Write channels: address and data taken in either order, one write in flight
  assign s_axi_awready = !awHave_ff && !bvalid_ff;
  assign s_axi_wready  = !wHave_ff && !bvalid_ff;
  assign doWrite       = awHave_ff && wHave_ff && !bvalid_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHave_ff <= 1'b0;
      awAddr_ff <= 64'h0000_0000_0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wHave_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_ff <= 1'b0;
    end
  end

  // Control register takes byte-lane writes; capability word ignores writes
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (doWrite && wrHit && (awAddr_ff[7:0] == `HCF_CTRL_OFFS)) begin
      for (int i = 0; i < 4; i++) begin
        if (wStrb_ff[i]) begin
          nxt_ctrl[i*8 +: 8] = wData_ff[i*8 +: 8];
        end
      end
    end
    nxt_ctrl[31:7] = 25'h0000000;
  end

  // Control register; only bits 6:0 are implemented
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `HCF_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Write response: unmapped or out-of-window address gets SLVERR
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `HCF_RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      // A write to the flags is accepted but dropped
      bresp_ff  <= (wrHit && (awAddr_ff[7:0] == `HCF_CTRL_OFFS ||
                    awAddr_ff[7:0] == `HCF_CAP_OFFS)) ? `HCF_RESP_OKAY : `HCF_RESP_SLVERR; // RULE18
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Status view of the decoded mode
  always_comb begin
    statWord = 32'h0000_0000;
    statWord[`HCF_STAT_WIDEDMA]  = wideDmaActive;
    statWord[`HCF_STAT_SIMPLEOK] = simpleWideOk;
    statWord[`HCF_STAT_DESC128]  = desc128Sel;
    statWord[`HCF_STAT_DESC96]   = desc96Sel;
    statWord[`HCF_STAT_BUS8OK]   = bus8Usable;
    statWord[`HCF_STAT_DEC64]    = dec64;
    statWord[`HCF_STAT_ADMAERR]  = advDmaErr;
  end

  // Read mux; the version word also carries the arbitrary revision tag
  always_comb begin
    rdValue = 32'h0000_0000;
    unique case (s_axi_araddr[7:0])
      `HCF_CAP_OFFS:  rdValue = capFlags_ff;
      `HCF_CTRL_OFFS: rdValue = ctrl_ff;
      `HCF_STAT_OFFS: rdValue = statWord;
      `HCF_VER_OFFS:  rdValue = {20'h00000, ID_REVISION, CTRL_VERSION};
      default:        rdValue = 32'h0000_0000;
    endcase
  end

  // Read answers one cycle after the address is taken
  assign s_axi_arready = !rvalid_ff;
  assign doRead        = s_axi_arvalid && s_axi_arready;

  // Read data sits in flops so a stalled rready always sees a stable word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `HCF_RESP_OKAY;
    end else if (doRead) begin
      rvalid_ff <= 1'b1;
      if (rdHit && (s_axi_araddr[7:0] == `HCF_CAP_OFFS || s_axi_araddr[7:0] == `HCF_CTRL_OFFS
          || s_axi_araddr[7:0] == `HCF_STAT_OFFS || s_axi_araddr[7:0] == `HCF_VER_OFFS)) begin
        rdata_ff <= rdValue;
        rresp_ff <= `HCF_RESP_OKAY;
      end else begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= `HCF_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
endmodule

// ==== design/hcf_consts.svh ====
// Offsets, field positions, reset values and codes for the capability flag block
`ifndef HCF_CONSTS_SVH
`define HCF_CONSTS_SVH

// Register byte offsets
`define HCF_CAP_OFFS       8'h00
`define HCF_CTRL_OFFS      8'h04
`define HCF_STAT_OFFS      8'h08
`define HCF_VER_OFFS       8'h0C

// Capability flag positions
`define HCF_BIT_V3WIDE     28
`define HCF_BIT_V4WIDE     27
`define HCF_BIT_SUSPEND    23
`define HCF_BIT_SIMPLEDMA  22
`define HCF_BIT_HIGHSPEED  21
`define HCF_BIT_LEGACYADMA 20
`define HCF_BIT_ADMA2      19
`define HCF_BIT_BUS8       18
`define HCF_BLK_LSB        16

// Control register positions
`define HCF_CTRL_V4SEL     0
`define HCF_CTRL_WIDEEN    1
`define HCF_CTRL_DMA_LSB   2
`define HCF_CTRL_SLOT_LSB  4
`define HCF_CTRL_PRESET8   6

// Status register positions
`define HCF_STAT_WIDEDMA   0
`define HCF_STAT_SIMPLEOK  1
`define HCF_STAT_DESC128   2
`define HCF_STAT_DESC96    3
`define HCF_STAT_BUS8OK    4
`define HCF_STAT_DEC64     5
`define HCF_STAT_ADMAERR   6

// Codes
`define HCF_DMA_ADMA2      2'h3
`define HCF_SLOT_SHARED    2'h2
`define HCF_BLK_512        2'h0
`define HCF_BLK_1024       2'h1
`define HCF_BLK_2048       2'h2
`define HCF_BLK_RSVD       2'h3
`define HCF_VER_300        8'h02
`define HCF_VER_400        8'h03
`define HCF_VER_410        8'h04

// Reset value of the control register
`define HCF_CTRL_RESET     32'h0000_0000

// AXI responses
`define HCF_RESP_OKAY      2'h0
`define HCF_RESP_SLVERR    2'h2

`endif

// ==== design/hcf_pkg.sv ====
// Types shared by the capability flag block
package hcf_pkg;
  typedef enum logic [1:0] {
    HCF_MODE_NONE,
    HCF_MODE_V3,
    HCF_MODE_V4
  } hcf_addr_mode_t;
endpackage

// ==== design/hcf_mode_decode.sv ====
// Addressing mode and DMA format decode from flags, version and control bits
`timescale 1ns/10ps
`include "hcf_consts.svh"
module hcf_mode_decode
  import hcf_pkg::*;
(
  // Flags and version
  input  wire logic                 v3WideAddrCap,
  input  wire logic                 v4WideAddrCap,
  input  wire logic [7:0]           ctrlVersion,
  // Software control
  input  wire logic                 v4ModeSelect,
  input  wire logic                 wideDmaAddrEn,
  input  wire logic [1:0]           dmaModeSel,
  // Decoded mode
  output hcf_pkg::hcf_addr_mode_t   addrMode,
  output logic                      wideDmaActive,
  output logic                      simpleWideOk,
  output logic                      desc128Sel,
  output logic                      desc96Sel,
  output logic                      advDmaErr
);
  import hcf_pkg::*;
  logic isV4Ctrl;
  logic advReq;

  // Version 4.00 and later pick a mode by the select bit
  assign isV4Ctrl = (ctrlVersion >= `HCF_VER_400);
  assign advReq   = (dmaModeSel == `HCF_DMA_ADMA2);

  // A mode is only entered when its flag allows it
  always_comb begin
    addrMode = HCF_MODE_NONE;
    if (isV4Ctrl) begin // RULE1
      if (v4ModeSelect && v4WideAddrCap) begin // RULE2
        addrMode = HCF_MODE_V4;
      end else if (!v4ModeSelect && v3WideAddrCap) begin // RULE2
        addrMode = HCF_MODE_V3;
      end
    end else if (v3WideAddrCap) begin
      addrMode = HCF_MODE_V3;
    end
  end

  // Wide DMA addressing needs the enable bit from 4.00 on
  assign wideDmaActive = (addrMode != HCF_MODE_NONE) && (!isV4Ctrl || wideDmaAddrEn); // RULE3
  // Simple DMA with wide addresses only in the newer mode
  assign simpleWideOk  = wideDmaActive && (addrMode == HCF_MODE_V4); // RULE4
  // Descriptor width follows the mode select
  assign desc128Sel    = advReq && wideDmaActive && (addrMode == HCF_MODE_V4); // RULE5
  // The 96-bit form needs the older flag; on 3.00 it is picked by code 11b
  assign desc96Sel     = advReq && wideDmaActive && v3WideAddrCap
                         && (addrMode == HCF_MODE_V3); // RULE5 RULE6 RULE7
  // Advanced DMA asked with wide addressing but no legal descriptor form
  assign advDmaErr     = advReq && wideDmaAddrEn && !desc128Sel && !desc96Sel; // RULE6
endmodule

// ==== tb/hcf_cap_regs_asserts.sv ====
// Port-level checks for the capability flag register bank
`timescale 1ns/10ps
module hcf_cap_regs_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Decoded mode
  input wire logic        wideDmaActive,
  input wire logic        simpleWideOk,
  input wire logic        desc128Sel,
  input wire logic        desc96Sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Write steps: both channels taken, a quiet edge, then the answer
  sequence wrTaken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wrAnswer_s;
    ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence rdTaken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // Mode outputs move only when a control write completes
  wide_on_write_a: assert property ($rose(wideDmaActive) |-> $rose(s_axi_bvalid))
    else $error("wide addressing rose without a control write");
  mode_on_write_a: assert property (!$stable({simpleWideOk, desc128Sel, desc96Sel})
    |-> $rose(s_axi_bvalid)) else $error("mode changed without a control write");
  simple_newer_a: assert property (simpleWideOk |-> wideDmaActive && !desc96Sel)
    else $error("wide simple transfers outside the newer mode");
  desc_single_a: assert property (!(desc128Sel && desc96Sel))
    else $error("both descriptor sizes selected");
  desc_wide_a: assert property (desc128Sel |-> simpleWideOk)
    else $error("long descriptor outside the newer mode");
  desc_short_a: assert property (desc96Sel |-> wideDmaActive && !simpleWideOk)
    else $error("short descriptor outside the older mode");
  write_answer_a: assert property (wrTaken_s |-> wrAnswer_s)
    else $error("write answer not two edges after acceptance");
  read_answer_a: assert property (rdTaken_s |=> s_axi_rvalid)
    else $error("read answer not one edge after acceptance");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer not held");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer not held");
endmodule

// ==== tb/hcf_host_model.sv ====
// Host bus master model issuing single register reads and writes
`timescale 1ns/10ps
module hcf_host_model (
  // Clock
  input  wire logic        clock,
  // Write channels
  output logic [63:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [63:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus; register traffic only, no card commands or block lengths
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 164'h0;
  end

  // Write: ready sampled at negedge, stable until the next rising edge
  task automatic wr(input logic [63:0] a, input logic [31:0] d, input int dly);
    int n;
    logic ha, hw, hb, done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (dly == 0);
    while (!done) begin
      @(negedge clock);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bready && s_axi_bvalid;
      @(posedge clock);
      n++;
      // Released lines show the inverse so stale values never pass
      if (ha) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (hw) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (hb) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end else if (n == dly) s_axi_bready <= 1'b1;
    end
    // Let one edge pass so the next call never re-drives a line in this step
    @(posedge clock);
  endtask

  // Read: rready may be held back to stall the answer
  task automatic rd(input logic [63:0] a, input int dly);
    int n;
    logic ha, hr, done;
    n = 0;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (dly == 0);
    while (!done) begin
      @(negedge clock);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rready && s_axi_rvalid;
      @(posedge clock);
      n++;
      if (ha) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (hr) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end else if (n == dly) s_axi_rready <= 1'b1;
    end
    // Let one edge pass so the next call never re-drives a line in this step
    @(posedge clock);
  endtask
endmodule

// ==== tb/host_capability_flags_wide_addr_tb.sv ====
// Self-checking bench for the capability flag register bank
`timescale 1ns/10ps
`include "hcf_consts.svh"
module host_capability_flags_wide_addr_tb;
  localparam logic [31:0] FMASK = 32'h18FF_0000;
  logic        clock, rst_n;
  logic        strapV3Wide, strapV4Wide, strapSuspend, strapSimpleDma, strapHighSpeed;
  logic        strapLegacyAdma, strapAdma2, strapAdma3, strapBus8;
  logic [63:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, s, c, f;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        wideDmaActive, simpleWideOk, desc128Sel, desc96Sel, bus8Usable;
  logic [65:0] qr[$];
  logic [1:0]  qb[$];
  logic [65:0] e;
  logic [6:0]  st;
  int          failCount, testsRun, seed;

  hcf_cap_regs #(.BLK_SIZE_CODE(`HCF_BLK_2048)) uut (.*);
  hcf_host_model host (.*);

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Driver notes the expected answer before each request
  task automatic rdExp(input logic [63:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [1:0] r, input int dly);
    qr.push_back({r, m, d & m});
    host.rd(a, dly);
  endtask
  task automatic wrExp(input logic [63:0] a, input logic [31:0] d, input logic [1:0] r,
                       input int dly);
    qb.push_back(r);
    host.wr(a, d, dly);
  endtask

  // Expected status: err, dec64, bus8, desc96, desc128, simple, wide
  function automatic logic [6:0] expSt(input logic [6:0] k, input logic v3, v4, b8);
    logic m3, m4, w, d3;
    m4 = k[0] & v4;
    m3 = !k[0] & v3;
    w = k[1] & (m3 | m4);
    d3 = (k[3:2] == 2'h3);
    return {k[1] & d3 & !w, v4, (k[5:4] == 2'h2) ? k[6] : b8, w & m3 & d3, w & m4 & d3,
            w & m4, w};
  endfunction

  // Oldest note is compared with each answer as the master takes it
  always @(negedge clock) begin
    if (rst_n && s_axi_rvalid && s_axi_rready) begin
      e = qr.pop_front();
      check({s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
    end
    if (rst_n && s_axi_bvalid && s_axi_bready) begin
      check({32'h0, s_axi_bresp}, {32'h0, qb.pop_front()});
    end
  end

  task automatic end_sim();
    $display("Checks run %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Each round: random straps, reset, flag reads, then random control words
  initial begin
    seed = 74;
    failCount = 0;
    testsRun = 0;
    rst_n = 1'b0;
    {strapBus8, strapAdma3, strapAdma2, strapLegacyAdma, strapHighSpeed} = 5'h00;
    {strapSimpleDma, strapSuspend, strapV4Wide, strapV3Wide} = 4'h0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      s = $random(seed);
      s[1:0] = i[1:0];
      rst_n <= 1'b0;
      {strapBus8, strapAdma3, strapAdma2, strapLegacyAdma, strapHighSpeed, strapSimpleDma,
       strapSuspend, strapV4Wide, strapV3Wide} <= s[8:0];
      repeat (i == 0 ? 6 : 2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      f = {3'h0, s[0], s[1], 3'h0, s[2], s[3] | s[6] | s[7], s[4], s[5], s[6] | s[7], s[8],
           `HCF_BLK_2048, 16'h0};
      rdExp(64'h0, f, FMASK, `HCF_RESP_OKAY, 0);
      wrExp(64'h0, ~f, `HCF_RESP_OKAY, 1);
      rdExp(64'h0, f, FMASK, `HCF_RESP_OKAY, 2);
      rdExp(64'h1_0000_0000, s[1] ? 32'h0 : f, s[1] ? 32'hFFFF_FFFF : FMASK,
            s[1] ? `HCF_RESP_SLVERR : `HCF_RESP_OKAY, 0);
      rdExp(`HCF_VER_OFFS, {24'h0, `HCF_VER_410}, 32'h0000_00FF, `HCF_RESP_OKAY, 0);
      rdExp(64'h10, 32'h0, 32'hFFFF_FFFF, `HCF_RESP_SLVERR, 0);
      wrExp(`HCF_STAT_OFFS, s, `HCF_RESP_SLVERR, 0);
      for (int j = 0; j < 8; j++) begin
        c = $random(seed) | ((j < 4) ? 32'hE : 32'h0);
        st = expSt(c[6:0], s[0], s[1], s[8]);
        wrExp(`HCF_CTRL_OFFS, c, `HCF_RESP_OKAY, j % 3);
        rdExp(`HCF_CTRL_OFFS, c & 32'h7F, 32'hFFFF_FFFF, `HCF_RESP_OKAY, 0);
        rdExp(`HCF_STAT_OFFS, {25'h0, st}, 32'h7F, `HCF_RESP_OKAY, j % 2);
        @(negedge clock);
        check({29'h0, bus8Usable, desc96Sel, desc128Sel, simpleWideOk, wideDmaActive},
              {29'h0, st[4:0]});
        @(posedge clock);
      end
      $display("Reset round %0d done", i);
    end
    end_sim();
  end

  // Watchdog, far beyond the expected run length
  initial begin
    #400000;
    failCount++;
    $display("Watchdog expired");
    end_sim();
  end
endmodule

bind hcf_cap_regs hcf_cap_regs_asserts chk (.*);
